/* File: design/ext_regs.vh */
`ifndef EXT_REGS_VH
`define EXT_REGS_VH
// ----------
// register indices and reset values
// ----------
`define EXT_IDX_DRAM_TIMING     8'h32
`define EXT_IDX_OVERFLOW_HIGH   8'h35
`define EXT_IDX_SYS_CONFIG_ONE  8'h36
`define EXT_RST_DRAM_TIMING     8'h00
`define EXT_RST_OVERFLOW_HIGH   8'h00
`define EXT_RST_SYS_CONFIG_ONE  8'h40
`define EXT_RST_CRTC_INDEX      8'h00
// ----------
// dram_cycle_timing fields
// ----------
`define EXT_DCT_WMASK           8'h7f
`define EXT_DCT_HOLD            6
`define EXT_DCT_RCD             5
`define EXT_DCT_RSP_HI          4
`define EXT_DCT_RSP_LO          3
`define EXT_DCT_CSP             2
`define EXT_DCT_CSW_HI          1
`define EXT_DCT_CSW_LO          0
// ----------
// vertical_overflow_high fields
// ----------
`define EXT_OVH_INTERLACE       7
`define EXT_OVH_IRQ_SEL         6
`define EXT_OVH_GENLOCK         5
`define EXT_OVH_LINE_CMP        4
`define EXT_OVH_VSYNC_START     3
`define EXT_OVH_VDISP_END       2
`define EXT_OVH_VTOTAL          1
`define EXT_OVH_VBLANK_START    0
// ----------
// system_config_one fields
// ----------
`define EXT_SC1_IO_WIDE         7
`define EXT_SC1_MEM_WIDE        6
`define EXT_SC1_MMIO_EN         5
`define EXT_SC1_LINEAR_MAP      4
`define EXT_SC1_BUFFER_EN       3
`define EXT_SC1_REFRESH_HI      2
`define EXT_SC1_REFRESH_LO      0
// ----------
// timing counts in memory clocks
// ----------
`define EXT_RCD_SET_CLKS        3'h3
`define EXT_RCD_CLR_CLKS        3'h2
`define EXT_RSP_OFFSET_CLKS     3'h2
`define EXT_CSP_OFFSET_CLKS     3'h1
`endif

/* File: design/ext_dram_timer.v */
`timescale 1ns/1ns
`include "ext_regs.vh"
module ext_dram_timer (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       start,
  input  wire [3:0] casCount,
  input  wire [7:0] timing,
  input  wire       textMode,
  output reg        busy,
  output reg        rasN,
  output reg        casLowPairN,
  output reg        casHighPairN
);
  localparam S_IDLE = 5'h01;
  localparam S_RCD  = 5'h02;
  localparam S_CAS  = 5'h04;
  localparam S_CPRE = 5'h08;
  localparam S_RPRE = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [2:0] cnt;
  reg [2:0] next_cnt;
  reg [3:0] left;
  reg [3:0] next_left;
  reg [7:0] cfg;
  reg [2:0] lowW;
  reg [2:0] highW;
  reg [2:0] phaseLen;
  reg [2:0] rcdLen;
  reg [2:0] rspLen;
  reg [2:0] cspLen;
  reg [2:0] hold;
  reg       lastCas;

  always @* begin
    hold    = {2'b00, cfg[`EXT_DCT_HOLD]};
    rcdLen  = cfg[`EXT_DCT_RCD] ? `EXT_RCD_SET_CLKS
                                : `EXT_RCD_CLR_CLKS;                // [R3]
    rspLen  = {1'b0, cfg[`EXT_DCT_RSP_HI:`EXT_DCT_RSP_LO]}
              + `EXT_RSP_OFFSET_CLKS - hold;                        // [R4] [R1]
    cspLen  = {2'b00, cfg[`EXT_DCT_CSP]} + `EXT_CSP_OFFSET_CLKS;    // [R5]
    case (cfg[`EXT_DCT_CSW_HI:`EXT_DCT_CSW_LO])                     // [R6]
      2'b01:   lowW = 3'h2;
      default: lowW = 3'h1;
    endcase
    highW   = textMode ? ({1'b0, cfg[`EXT_DCT_CSW_HI:`EXT_DCT_CSW_LO]}
              + 3'h1) : lowW;
    lastCas = (left == 4'h1);
    // the final cas of the cycle carries the hold extension
    phaseLen = ((highW > lowW) ? highW : lowW)
               + (lastCas ? hold : 3'h0);                           // [R1]
    next_state = state;
    next_cnt   = cnt + 3'h1;
    next_left  = left;
    case (state)                                                    // [R2]
      S_IDLE: begin
        next_cnt = 3'h0;
        if (start) begin
          next_state = S_RCD;
        end
      end
      S_RCD: begin
        if (cnt == rcdLen - 3'h1) begin
          next_state = S_CAS;
          next_cnt   = 3'h0;
        end
      end
      S_CAS: begin
        if (cnt == phaseLen - 3'h1) begin
          next_cnt  = 3'h0;
          next_left = left - 4'h1;
          next_state = lastCas ? S_RPRE : S_CPRE;
        end
      end
      S_CPRE: begin
        if (cnt == cspLen - 3'h1) begin
          next_state = S_CAS;
          next_cnt   = 3'h0;
        end
      end
      S_RPRE: begin
        if (cnt == rspLen - 3'h1) begin
          next_state = S_IDLE;
          next_cnt   = 3'h0;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_cnt   = 3'h0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state        <= S_IDLE;
      cnt          <= 3'h0;
      left         <= 4'h0;
      cfg          <= `EXT_RST_DRAM_TIMING;
      busy         <= 1'b0;
      rasN         <= 1'b1;
      casLowPairN  <= 1'b1;
      casHighPairN <= 1'b1;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      left  <= next_left;
      if (state == S_IDLE && start) begin
        // settings freeze per cycle, so a write never bends one in flight
        cfg  <= timing;                                             // [R20]
        left <= (casCount == 4'h0) ? 4'h1 : casCount;
      end
      busy <= (next_state != S_IDLE);
      rasN <= !(next_state == S_RCD || next_state == S_CAS ||
                next_state == S_CPRE);                              // [R2]
      casLowPairN  <= !(next_state == S_CAS &&
                        (next_cnt < lowW || lastCas && next_cnt >= lowW
                         && next_cnt < lowW + hold));
      casHighPairN <= !(next_state == S_CAS &&
                        (next_cnt < highW || lastCas && next_cnt >= highW
                         && next_cnt < highW + hold));
    end
  end
endmodule

/* File: design/ext_config_regs.v */
`timescale 1ns/1ns
`include "ext_regs.vh"
// Contract
// R1 - hold bit stretches ras and last cas
// R2 - ras low and high sums from timings
// R3 - ras-to-cas delay three or two clocks
// R4 - ras precharge is field plus two
// R5 - cas precharge is field plus one
// R6 - cas low width table per mode, pair
// R7 - interlace scans odd lines then even
// R8 - interrupt source select secondary or main
// R9 - genlock sync resets counters, redefines tokens
// R10 - image port makes sync a mask
// R11 - five low bits are vertical bit10s
// R12 - io width bit selects 16 or 8
// R13 - memory width bit, default sixteen bit
// R14 - mmio decode needs mmio and buffer enables
// R15 - linear map exposes flat memory area
// R16 - buffer enable opens three apertures
// R17 - refresh field plus one per line
// R18 - extended writes need unlock key set; overflow-high writes here ignore the key and check only protect
// R19 - overflow-high writes need protect clear
// R20 - reserved read zero, timing per cycle
module ext_config_regs #(
  parameter LOCAL_BUS = 1'b1
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        ioWrite,
  input  wire        ioRead,
  input  wire        ioSelData,
  input  wire [7:0]  ioWrData,
  input  wire        unlockKey,
  input  wire        overflowProtect,
  input  wire        textMode,
  input  wire        imagePortEnable,
  input  wire        external_sync_input,
  input  wire        mainVertEvent,
  input  wire        secondaryVertEvent,
  input  wire        frameStart,
  input  wire        lineStart,
  input  wire [1:0]  tokenDefault,
  input  wire        memReq,
  input  wire [3:0]  memCasCount,
  output reg  [7:0]  ioRdData,
  output reg  [7:0]  dram_cycle_timing,
  output reg  [7:0]  vertical_overflow_high,
  output reg  [7:0]  system_config_one,
  output reg  [4:0]  vertBit10,
  output reg         interlaceEn,
  output reg         evenField,
  output reg         vertIrq,
  output reg         counterReset,
  output reg         imageByteMask,
  output reg  [1:0]  token_outputs,
  output reg         ioWide16,
  output reg  [1:0]  hostMemWidth,
  output reg         mmioDecodeEn,
  output reg         linearMapEn,
  output reg  [2:0]  apertureEn,
  output reg         memAck,
  output reg         refreshActive,
  output reg         rasN,
  output reg         casLowPairN,
  output reg         casHighPairN
);
  // hostMemWidth codes: 0 = 8-bit, 1 = 16-bit, 2 = 32-bit
  localparam MW_8  = 2'h0;
  localparam MW_16 = 2'h1;
  localparam MW_32 = 2'h2;

  localparam A_IDLE = 3'h1;
  localparam A_MEM  = 3'h2;
  localparam A_REF  = 3'h4;

  reg  [7:0] crtcIndex;
  reg        syncMeta;
  reg        syncSafe;
  reg  [3:0] refreshLeft;
  reg  [2:0] arbState;
  reg        timerStart;
  reg  [3:0] timerCas;
  wire       timerBusy;
  wire       tRasN;
  wire       tCasLowN;
  wire       tCasHighN;
  wire       wrData;
  wire       wrKeyed;
  wire       wrTiming;
  wire       wrOverflow;
  wire       wrConfig;

  // ---------------------------------------------------------------
  // index/data port decode
  // ---------------------------------------------------------------
  assign wrData     = ioWrite && ioSelData;
  assign wrKeyed    = wrData && unlockKey;                          // [R18]
  assign wrTiming   = wrKeyed && (crtcIndex == `EXT_IDX_DRAM_TIMING);
  assign wrConfig   = wrKeyed && (crtcIndex == `EXT_IDX_SYS_CONFIG_ONE);
  // overflow-high ignores the key and obeys only the protect bit
  assign wrOverflow = wrData && !overflowProtect &&
                      (crtcIndex == `EXT_IDX_OVERFLOW_HIGH);        // [R19]

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      crtcIndex              <= `EXT_RST_CRTC_INDEX;
      dram_cycle_timing      <= `EXT_RST_DRAM_TIMING;
      vertical_overflow_high <= `EXT_RST_OVERFLOW_HIGH;
      // io width powers up wide only on a local bus
      system_config_one      <= `EXT_RST_SYS_CONFIG_ONE |
                                {LOCAL_BUS[0], 7'h00};              // [R12]
      ioRdData               <= 8'h00;
    end else begin
      if (ioWrite && !ioSelData) begin
        crtcIndex <= ioWrData;
      end
      if (wrTiming) begin
        dram_cycle_timing <= ioWrData & `EXT_DCT_WMASK;             // [R20]
      end
      if (wrOverflow) begin
        vertical_overflow_high <= ioWrData;
      end
      if (wrConfig) begin
        system_config_one <= ioWrData;
      end
      if (ioRead) begin
        if (!ioSelData) begin
          ioRdData <= crtcIndex;
        end else if (crtcIndex == `EXT_IDX_DRAM_TIMING) begin
          ioRdData <= dram_cycle_timing;
        end else if (crtcIndex == `EXT_IDX_OVERFLOW_HIGH) begin
          ioRdData <= vertical_overflow_high;
        end else if (crtcIndex == `EXT_IDX_SYS_CONFIG_ONE) begin
          ioRdData <= system_config_one;
        end else begin
          // other indices belong to neighbouring banks
          ioRdData <= 8'h00;                                        // [R20]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // external sync input synchroniser
  // ---------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncMeta <= 1'b0;
      syncSafe <= 1'b0;
    end else begin
      syncMeta <= external_sync_input;
      syncSafe <= syncMeta;
    end
  end

  // ---------------------------------------------------------------
  // display timing controls
  // ---------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      vertBit10     <= 5'h00;
      interlaceEn   <= 1'b0;
      evenField     <= 1'b0;
      vertIrq       <= 1'b0;
      counterReset  <= 1'b0;
      imageByteMask <= 1'b0;
      token_outputs <= 2'h0;
    end else begin
      vertBit10   <= vertical_overflow_high[`EXT_OVH_LINE_CMP:
                                            `EXT_OVH_VBLANK_START]; // [R11]
      interlaceEn <= vertical_overflow_high[`EXT_OVH_INTERLACE];
      // odd field first: with interlace set, each frame start flips to the other field
      if (!vertical_overflow_high[`EXT_OVH_INTERLACE]) begin
        evenField <= 1'b0;                                          // [R7]
      end else if (frameStart) begin
        evenField <= !evenField;                                    // [R7]
      end
      vertIrq <= vertical_overflow_high[`EXT_OVH_IRQ_SEL] ?
                 secondaryVertEvent : mainVertEvent;                // [R8]
      // resync costs three clocks of latency on the counter reset
      counterReset <= vertical_overflow_high[`EXT_OVH_GENLOCK] &&
                      !imagePortEnable && syncSafe;                 // [R9] [R10]
      imageByteMask <= imagePortEnable && syncSafe;                 // [R10]
      if (vertical_overflow_high[`EXT_OVH_GENLOCK]) begin
        token_outputs <= {vertical_overflow_high[`EXT_OVH_INTERLACE],
                          evenField};                               // [R9]
      end else begin
        token_outputs <= tokenDefault;
      end
    end
  end

  // ---------------------------------------------------------------
  // host path configuration
  // ---------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ioWide16     <= LOCAL_BUS[0];
      hostMemWidth <= MW_16;
      mmioDecodeEn <= 1'b0;
      linearMapEn  <= 1'b0;
      apertureEn   <= 3'h0;
    end else begin
      ioWide16 <= system_config_one[`EXT_SC1_IO_WIDE];              // [R12]
      if (system_config_one[`EXT_SC1_MEM_WIDE]) begin
        hostMemWidth <= MW_16;                                      // [R13]
      end else begin
        hostMemWidth <= LOCAL_BUS ? MW_32 : MW_8;                   // [R13]
      end
      mmioDecodeEn <= system_config_one[`EXT_SC1_MMIO_EN] &&
                      system_config_one[`EXT_SC1_BUFFER_EN];        // [R14]
      linearMapEn  <= system_config_one[`EXT_SC1_LINEAR_MAP];       // [R15]
      apertureEn   <= {3{system_config_one[`EXT_SC1_BUFFER_EN]}};   // [R16]
    end
  end

  // ---------------------------------------------------------------
  // refresh and host cycle arbitration
  // ---------------------------------------------------------------
  // refresh wins over host cycles so a line never falls short
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      refreshLeft   <= 4'h0;
      arbState      <= A_IDLE;
      timerStart    <= 1'b0;
      timerCas      <= 4'h1;
      memAck        <= 1'b0;
      refreshActive <= 1'b0;
    end else begin
      timerStart <= 1'b0;
      memAck     <= 1'b0;
      case (arbState)
        A_IDLE: begin
          if (!timerBusy && !timerStart) begin
            if (refreshLeft != 4'h0) begin
              timerStart    <= 1'b1;
              timerCas      <= 4'h1;
              arbState      <= A_REF;
              refreshActive <= 1'b1;
            end else if (memReq) begin
              timerStart <= 1'b1;
              timerCas   <= memCasCount;
              arbState   <= A_MEM;
              memAck     <= 1'b1;
            end
          end
        end
        A_MEM: begin
          if (timerBusy) begin
            arbState <= A_IDLE;
          end
        end
        A_REF: begin
          if (timerBusy) begin
            arbState      <= A_IDLE;
            refreshActive <= 1'b0;
          end
        end
        default: begin
          arbState <= A_IDLE;
        end
      endcase
      if (lineStart) begin
        refreshLeft <= {1'b0, system_config_one[`EXT_SC1_REFRESH_HI:
                                                `EXT_SC1_REFRESH_LO]}
                       + 4'h1;                                      // [R17]
      end else if (arbState == A_IDLE && !timerBusy && !timerStart &&
                   refreshLeft != 4'h0) begin
        refreshLeft <= refreshLeft - 4'h1;                          // [R17]
      end
    end
  end

  // ---------------------------------------------------------------
  // dram strobe sequencer
  // ---------------------------------------------------------------
  ext_dram_timer u_timer (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .start        (timerStart),
    .casCount     (timerCas),
    .timing       (dram_cycle_timing),
    .textMode     (textMode),
    .busy         (timerBusy),
    .rasN         (tRasN),
    .casLowPairN  (tCasLowN),
    .casHighPairN (tCasHighN)
  );

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rasN         <= 1'b1;
      casLowPairN  <= 1'b1;
      casHighPairN <= 1'b1;
    end else begin
      rasN         <= tRasN;                                        // [R2]
      casLowPairN  <= tCasLowN;
      casHighPairN <= tCasHighN;
    end
  end
endmodule

/* File: verif/ext_config_regs_props.sv */
`timescale 1ns/1ns
module ext_config_regs_props #(
  parameter LOCAL_BUS = 1'b1
) (
  input wire       sys_clk,
  input wire       rstn,
  input wire       ioWrite,
  input wire       ioSelData,
  input wire       unlockKey,
  input wire       overflowProtect,
  input wire       mainVertEvent,
  input wire       secondaryVertEvent,
  input wire [7:0] dram_cycle_timing,
  input wire [7:0] vertical_overflow_high,
  input wire [7:0] system_config_one,
  input wire [4:0] vertBit10,
  input wire       interlaceEn,
  input wire       vertIrq,
  input wire       ioWide16,
  input wire [1:0] hostMemWidth,
  input wire       mmioDecodeEn,
  input wire [2:0] apertureEn,
  input wire       memAck,
  input wire       rasN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------
  // register port
  // ----------
  key_lock_a: assert property (
    ioWrite && ioSelData && !unlockKey
    |=> $stable(dram_cycle_timing) && $stable(system_config_one))
    else $error("locked write changed a register");
  overflow_protect_a: assert property (
    ioWrite && ioSelData && overflowProtect
    |=> $stable(vertical_overflow_high))
    else $error("protected overflow register changed");
  reserved_bit_a: assert property (
    dram_cycle_timing[7] == 1'b0)
    else $error("reserved timing bit set");
  // ----------
  // decoded controls, one clock behind the registers
  // ----------
  vert_bits_a: assert property (
    vertBit10 == $past(vertical_overflow_high[4:0]))
    else $error("vertical bit ten mismatch");
  interlace_out_a: assert property (
    interlaceEn == $past(vertical_overflow_high[7]))
    else $error("interlace enable mismatch");
  irq_source_a: assert property (
    vertIrq == $past(vertical_overflow_high[6] ? secondaryVertEvent
                                               : mainVertEvent))
    else $error("vertical interrupt source mismatch");
  mmio_gate_a: assert property (
    mmioDecodeEn == $past(system_config_one[5] & system_config_one[3]))
    else $error("mapped register decode mismatch");
  aperture_set_a: assert property (
    apertureEn == {3{$past(system_config_one[3])}})
    else $error("aperture enables mismatch");
  io_width_a: assert property (
    ioWide16 == $past(system_config_one[7]))
    else $error("io width mismatch");
  mem_width_a: assert property (
    hostMemWidth == ($past(system_config_one[6]) ? 2'h1 :
                     (LOCAL_BUS ? 2'h2 : 2'h0)))
    else $error("memory width mismatch");
  // ----------
  // dram cycle shape
  // ----------
  ras_start_a: assert property (
    memAck |-> ##[1:4] !rasN)
    else $error("ras did not start after acknowledge");
  ras_min_low_a: assert property (
    $fell(rasN) |-> !rasN [*3])
    else $error("ras low shorter than delay plus one cas");
endmodule

/* File: verif/ext_dram_host_model.sv */
`timescale 1ns/1ns
module ext_dram_host_model (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       go,
  input  wire [3:0] casCount,
  input  wire       memAck,
  input  wire       rasN,
  output reg        memReq,
  output reg  [3:0] memCasCount,
  output reg        lenValid,
  output reg  [7:0] lowLen,
  output reg  [7:0] rasFalls
);
  reg [7:0] lowCnt;
  reg       rasPrev;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      memReq      <= 1'b0;
      memCasCount <= 4'h0;
      lenValid    <= 1'b0;
      lowLen      <= 8'h00;
      rasFalls    <= 8'h00;
      lowCnt      <= 8'h00;
      rasPrev     <= 1'b1;
    end else begin
      rasPrev <= rasN;
      if (go) begin
        memReq      <= 1'b1;
        memCasCount <= casCount;
        lenValid    <= 1'b0;
      end else if (memReq && memAck) begin
        // released count is scrambled so a stale value is never reused
        memReq      <= 1'b0;
        memCasCount <= ~memCasCount;
      end
      if (rasPrev && !rasN)
        rasFalls <= rasFalls + 8'h01;
      if (!rasN)
        lowCnt <= lowCnt + 8'h01;
      else if (lowCnt != 8'h00) begin
        lowLen   <= lowCnt;
        lowCnt   <= 8'h00;
        lenValid <= 1'b1;
      end
    end
  end
endmodule

/* File: verif/test_ext_config_regs.sv */
`timescale 1ns/1ns
`include "ext_regs.vh"
module test_ext_config_regs;
  reg        sys_clk;
  reg        rstn;
  reg        ioWrite;
  reg        ioRead;
  reg        ioSelData;
  reg  [7:0] ioWrData;
  reg        unlockKey;
  reg        overflowProtect;
  reg        imgEn;
  reg        syncIn;
  reg        mainEv;
  reg        secEv;
  reg        lineStart;
  reg        frame;
  reg        go;
  reg  [3:0] casCount;
  wire       memReq;
  wire       memAck;
  wire       rasN;
  wire [3:0] memCasCount;
  wire       lenValid;
  wire [7:0] lowLen;
  wire [7:0] rasFalls;
  wire [7:0] rd0;
  wire [4:0] vBits;
  wire       ilace;
  wire       irq;
  wire       cntRst;
  wire       byteMask;
  wire [1:0] tokens;
  wire       io16;
  wire [1:0] memW;
  wire       mmio;
  wire       linMap;
  wire [2:0] apert;
  reg  [7:0] rd;
  reg  [7:0] base;
  reg  [23:0] rows [0:5];
  reg  [23:0] dram [0:4];
  integer    err_total;
  integer    total_checks;
  integer    i;
  ext_config_regs dut (
    .sys_clk(sys_clk), .rstn(rstn), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioSelData(ioSelData), .ioWrData(ioWrData), .unlockKey(unlockKey),
    .overflowProtect(overflowProtect), .textMode(1'b0),
    .imagePortEnable(imgEn), .external_sync_input(syncIn),
    .mainVertEvent(mainEv), .secondaryVertEvent(secEv),
    .frameStart(frame), .lineStart(lineStart), .tokenDefault(2'h2),
    .memReq(memReq), .memCasCount(memCasCount), .ioRdData(rd0),
    .dram_cycle_timing(), .vertical_overflow_high(),
    .system_config_one(), .vertBit10(vBits), .interlaceEn(ilace),
    .evenField(), .vertIrq(irq), .counterReset(cntRst),
    .imageByteMask(byteMask), .token_outputs(tokens), .ioWide16(io16),
    .hostMemWidth(memW), .mmioDecodeEn(mmio), .linearMapEn(linMap),
    .apertureEn(apert), .memAck(memAck), .refreshActive(), .rasN(rasN),
    .casLowPairN(), .casHighPairN());
  ext_dram_host_model host (
    .sys_clk(sys_clk), .rstn(rstn), .go(go), .casCount(casCount),
    .memAck(memAck), .rasN(rasN), .memReq(memReq),
    .memCasCount(memCasCount), .lenValid(lenValid), .lowLen(lowLen),
    .rasFalls(rasFalls));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ----------
  // bus tasks and checks
  // ----------
  task put(input sel, input [7:0] d);
    begin
      @(posedge sys_clk);
      ioWrite   <= 1'b1;
      ioSelData <= sel;
      ioWrData  <= d;
    end
  endtask
  task regWr(input [7:0] idx, input [7:0] d);
    begin
      put(1'b0, idx);
      put(1'b1, d);
      @(posedge sys_clk);
      ioWrite <= 1'b0;
    end
  endtask
  task regRd(input [7:0] idx, output [7:0] d);
    begin
      put(1'b0, idx);
      @(posedge sys_clk);
      ioWrite   <= 1'b0;
      ioRead    <= 1'b1;
      ioSelData <= 1'b1;
      @(posedge sys_clk);
      ioRead <= 1'b0;
      @(posedge sys_clk);
      #1 d = rd0;
    end
  endtask
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge sys_clk);
      #1;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task waitLen;
    integer k;
    begin
      k = 0;
      #1;
      while (lenValid !== 1'b1 && k < 100) begin
        @(posedge sys_clk);
        #1 k = k + 1;
      end
      if (k == 100) begin
        err_total = err_total + 1;
        test_done;
      end
    end
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    {rstn, ioWrite, ioRead, ioSelData, ioWrData} = 12'h000;
    {overflowProtect, imgEn, syncIn, mainEv, secEv, lineStart} = 6'h00;
    frame = 1'b0;
    {go, casCount, unlockKey} = 6'h01;
    err_total = 0;
    total_checks = 0;
    // index, written, read back; unmapped index reads zero
    rows[0] = {`EXT_IDX_DRAM_TIMING, 8'hff, 8'h7f};
    rows[1] = {`EXT_IDX_DRAM_TIMING, 8'h25, 8'h25};
    rows[2] = {`EXT_IDX_OVERFLOW_HIGH, 8'ha5, 8'ha5};
    rows[3] = {`EXT_IDX_SYS_CONFIG_ONE, 8'h3b, 8'h3b};
    rows[4] = {`EXT_IDX_SYS_CONFIG_ONE, 8'hc4, 8'hc4};
    rows[5] = {8'h40, 8'h55, 8'h00};
    // timing byte, cas count, ras low clocks
    dram[0] = {8'h00, 8'h01, 8'h03};
    dram[1] = {8'h01, 8'h01, 8'h04};
    dram[2] = {8'h20, 8'h02, 8'h06};
    dram[3] = {8'h47, 8'h02, 8'h07};
    dram[4] = {8'h7f, 8'h03, 8'h0b};
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      regWr(rows[i][23:16], rows[i][15:8]);
      regRd(rows[i][23:16], rd);
      check("readback", rows[i][7:0], rd);
    end
    regWr(`EXT_IDX_SYS_CONFIG_ONE, 8'h28);
    settle;
    check("mmio", 8'h01, {7'h0, mmio});
    check("apertures", 8'h07, {5'h0, apert});
    check("mem width", 8'h02, {6'h0, memW});
    regWr(`EXT_IDX_SYS_CONFIG_ONE, 8'hf0);
    settle;
    check("mmio", 8'h00, {7'h0, mmio});
    check("io width", 8'h01, {7'h0, io16});
    check("linear", 8'h01, {7'h0, linMap});
    check("mem width", 8'h01, {6'h0, memW});
    unlockKey <= 1'b0;
    regWr(`EXT_IDX_SYS_CONFIG_ONE, 8'h05);
    regRd(`EXT_IDX_SYS_CONFIG_ONE, rd);
    check("locked", 8'hf0, rd);
    regWr(`EXT_IDX_OVERFLOW_HIGH, 8'h1f);
    regRd(`EXT_IDX_OVERFLOW_HIGH, rd);
    check("overflow", 8'h1f, rd);
    check("vert bits", 8'h1f, {3'h0, vBits});
    check("tokens", 8'h02, {6'h0, tokens});
    overflowProtect <= 1'b1;
    regWr(`EXT_IDX_OVERFLOW_HIGH, 8'h00);
    regRd(`EXT_IDX_OVERFLOW_HIGH, rd);
    check("protected", 8'h1f, rd);
    overflowProtect <= 1'b0;
    unlockKey <= 1'b1;
    regWr(`EXT_IDX_OVERFLOW_HIGH, 8'ha0);
    syncIn <= 1'b1;
    settle;
    check("interlace", 8'h01, {7'h0, ilace});
    check("token hi", 8'h01, {7'h0, tokens[1]});
    frame <= 1'b1;
    @(posedge sys_clk);
    frame <= 1'b0;
    settle;
    check("even field", 8'h01, {7'h0, tokens[0]});
    check("cnt reset", 8'h01, {7'h0, cntRst});
    check("byte mask", 8'h00, {7'h0, byteMask});
    imgEn <= 1'b1;
    settle;
    check("cnt reset", 8'h00, {7'h0, cntRst});
    check("byte mask", 8'h01, {7'h0, byteMask});
    {imgEn, syncIn} <= 2'h0;
    regWr(`EXT_IDX_OVERFLOW_HIGH, 8'h40);
    secEv <= 1'b1;
    settle;
    check("irq second", 8'h01, {7'h0, irq});
    {mainEv, secEv} <= 2'h2;
    settle;
    check("irq second", 8'h00, {7'h0, irq});
    mainEv <= 1'b0;
    regWr(`EXT_IDX_OVERFLOW_HIGH, 8'h00);
    mainEv <= 1'b1;
    settle;
    check("irq main", 8'h01, {7'h0, irq});
    mainEv <= 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      regWr(`EXT_IDX_DRAM_TIMING, dram[i][23:16]);
      casCount <= dram[i][11:8];
      @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      waitLen;
      check("ras low", dram[i][7:0], lowLen);
    end
    for (i = 0; i < 2; i = i + 1) begin
      regWr(`EXT_IDX_SYS_CONFIG_ONE, i ? 8'h45 : 8'h42);
      #1 base = rasFalls;
      @(posedge sys_clk);
      lineStart <= 1'b1;
      @(posedge sys_clk);
      lineStart <= 1'b0;
      repeat (120) @(posedge sys_clk);
      #1 check("refreshes", i ? 8'h06 : 8'h03, rasFalls - base);
    end
    // mid-run reset must restore all three extended registers
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    regRd(`EXT_IDX_DRAM_TIMING, rd);
    check("reset dct", `EXT_RST_DRAM_TIMING, rd);
    regRd(`EXT_IDX_OVERFLOW_HIGH, rd);
    check("reset ovh", `EXT_RST_OVERFLOW_HIGH, rd);
    regRd(`EXT_IDX_SYS_CONFIG_ONE, rd);
    check("reset sc1", `EXT_RST_SYS_CONFIG_ONE | 8'h80, rd);
    test_done;
  end
endmodule
bind ext_config_regs ext_config_regs_props #(.LOCAL_BUS(LOCAL_BUS)) props (
  .*);
